/* File: dsr_params.svh */
/*
  Timing counts, defaults and field encodings for the start, restart and fire-mode block.
  Assumes a 50 MHz system clock on ref_clk.
*/
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

`define DSR_CLK_HZ 50000000
`define DSR_RESTART_GAP_S 20
`define DSR_RESTART_GAP_CYC (`DSR_CLK_HZ * `DSR_RESTART_GAP_S)
`define DSR_MAX_ATTEMPTS 5
`define DSR_DEBOUNCE_CYC 16
`define DSR_START_MODE_RST 1'h0
`define DSR_AUTO_RESTART_RST 1'h0
`define DSR_FIRE_POL_RST 1'h0
`define DSR_FIRE_TYPE_RST 1'h0
`define DSR_FIRE_POL_NC 1'h0
`define DSR_FIRE_TYPE_MAINT 1'h0

`endif

/* File: dsr_pkg.sv */
/*
  Types for the start, restart and fire-mode block.
  Assumes nothing beyond the design file that uses it.
*/
package dsr_pkg;
  typedef enum logic [2:0] {
    DSR_IDLE = 3'h0,
    DSR_RUN = 3'h1,
    DSR_WAIT = 3'h3,
    DSR_TRIP = 3'h2
  } dsr_state_t;
endpackage

/* File: dsr_ctrl.sv */
/*
  Start-mode, automatic restart and fire-mode input control for a motor drive.
  Assumes run and fire contacts are synchronous to ref_clk; configuration inputs are held steady
  by the surrounding control logic; rst_n is the power-on reset.
*/
`include "dsr_params.svh"
// Notes on behaviour
// - Edge mode: start only on fresh closure.
// - Automatic mode: start if input already closed.
// - Up to five restarts, twenty seconds apart.
// - Count attempts; trip after last fails.
// - Tripped stays faulted until manual reset.
// - Attempt counter clears only at power-up.
// - Polarity zero: open input means fire.
// - Polarity one: closed input means fire.
// - Maintained type: fire only while active.
// - Momentary type: pulse enters fire mode.
// - Momentary fire holds until disabled.
// - Fire settings act only when assigned.
// - Defaults: edge start, restart disabled.
// - Fire polarity defaults to normally closed.
module dsr_ctrl #(
  parameter int RESTART_GAP_CYC = `DSR_RESTART_GAP_CYC,
  parameter int MAX_ATTEMPTS = `DSR_MAX_ATTEMPTS,
  parameter int DEBOUNCE_CYC = `DSR_DEBOUNCE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run_in,
  input wire logic fire_in,
  input wire logic cfg_valid,
  input wire logic cfg_auto_start,
  input wire logic cfg_auto_restart,
  input wire logic cfg_fire_pol,
  input wire logic cfg_fire_type,
  input wire logic fire_assigned,
  input wire logic fire_disable,
  input wire logic start_failed,
  input wire logic fault_reset,
  output logic motor_run,
  output logic fault_trip,
  output logic fire_mode,
  output logic [2:0] attempt_count
);

  localparam int GW = $clog2(RESTART_GAP_CYC + 1);
  localparam int DW = $clog2(DEBOUNCE_CYC + 1);
  localparam int SW = $clog2(DEBOUNCE_CYC + 5);

  logic auto_start_reg;
  logic auto_restart_reg;
  logic fire_pol_reg;
  logic fire_type_reg;
  logic [1:0] run_sync_reg;
  logic [1:0] fire_sync_reg;
  logic run_db_reg;
  logic fire_db_reg;
  logic [DW-1:0] run_cnt_reg;
  logic [DW-1:0] fire_cnt_reg;
  logic run_prev_reg;
  logic armed_reg;
  logic [SW-1:0] settle_cnt_reg;
  logic settled;
  logic [GW-1:0] gap_reg;
  logic fire_latch_reg;
  logic fire_active;
  logic run_rise;
  logic start_req;
  dsr_pkg::dsr_state_t state_reg;
  dsr_pkg::dsr_state_t state_next;

  // Configuration store, loaded when the setting strobe is high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auto_start_reg <= `DSR_START_MODE_RST;
      auto_restart_reg <= `DSR_AUTO_RESTART_RST;
      fire_pol_reg <= `DSR_FIRE_POL_RST;
      fire_type_reg <= `DSR_FIRE_TYPE_RST;
    end
    else if (cfg_valid)
    begin
      auto_start_reg <= cfg_auto_start;
      auto_restart_reg <= cfg_auto_restart;
      fire_pol_reg <= cfg_fire_pol;
      fire_type_reg <= cfg_fire_type;
    end
  end

  // Two-stage synchronisers for both contacts
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_sync_reg <= 2'h0;
      fire_sync_reg <= 2'h0;
    end
    else
    begin
      run_sync_reg <= {run_sync_reg[0], run_in};
      fire_sync_reg <= {fire_sync_reg[0], fire_in};
    end
  end

  // Debounce: a level change must persist for DEBOUNCE_CYC cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_db_reg <= 1'h0;
      fire_db_reg <= 1'h0;
      run_cnt_reg <= '0;
      fire_cnt_reg <= '0;
    end
    else
    begin
      if (run_sync_reg[1] == run_db_reg)
        run_cnt_reg <= '0;
      else if (run_cnt_reg == DW'(DEBOUNCE_CYC - 1))
      begin
        run_db_reg <= run_sync_reg[1];
        run_cnt_reg <= '0;
      end
      else
        run_cnt_reg <= run_cnt_reg + 1'b1;
      if (fire_sync_reg[1] == fire_db_reg)
        fire_cnt_reg <= '0;
      else if (fire_cnt_reg == DW'(DEBOUNCE_CYC - 1))
      begin
        fire_db_reg <= fire_sync_reg[1];
        fire_cnt_reg <= '0;
      end
      else
        fire_cnt_reg <= fire_cnt_reg + 1'b1;
    end
  end

  // Settle window: filtered levels read open after reset until the filters catch up
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_cnt_reg <= '0;
    else if (!settled)
      settle_cnt_reg <= settle_cnt_reg + 1'b1;
  end

  assign settled = settle_cnt_reg == SW'(DEBOUNCE_CYC + 4);

  // Edge start arms only once the settled run input has been seen open
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_prev_reg <= 1'h1;
      armed_reg <= 1'h0;
    end
    else
    begin
      run_prev_reg <= run_db_reg;
      if (settled && !run_db_reg)
        armed_reg <= 1'h1;
    end
  end

  assign run_rise = run_db_reg && !run_prev_reg && armed_reg;
  assign start_req = auto_start_reg ? run_db_reg : run_rise;

  // Fire contact level decoded through polarity
  assign fire_active = settled && fire_assigned && (fire_pol_reg == `DSR_FIRE_POL_NC ? !fire_db_reg
                                         : fire_db_reg);

  // Momentary fire latch, cleared only by disable, loss of fire_assigned or power loss
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fire_latch_reg <= 1'h0;
    else if (fire_disable || !fire_assigned)
      fire_latch_reg <= 1'h0;
    else if (fire_type_reg != `DSR_FIRE_TYPE_MAINT && fire_active)
      fire_latch_reg <= 1'h1;
  end

  // Fire mode output
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fire_mode <= 1'h0;
    else if (fire_type_reg == `DSR_FIRE_TYPE_MAINT)
      fire_mode <= fire_active && !fire_disable;
    else
      fire_mode <= (fire_latch_reg || fire_active) && !fire_disable && fire_assigned;
  end

  // Run / restart sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      dsr_pkg::DSR_IDLE:
        if (start_req)
          state_next = dsr_pkg::DSR_RUN;
      dsr_pkg::DSR_RUN:
        if (start_failed)
        begin
          if (!auto_restart_reg)
            state_next = dsr_pkg::DSR_TRIP;
          else if (attempt_count >= 3'(MAX_ATTEMPTS))
            state_next = dsr_pkg::DSR_TRIP;
          else
            state_next = dsr_pkg::DSR_WAIT;
        end
        else if (!run_db_reg)
          state_next = dsr_pkg::DSR_IDLE;
      dsr_pkg::DSR_WAIT:
        if (!run_db_reg)
          state_next = dsr_pkg::DSR_IDLE;
        else if (gap_reg == '0)
          state_next = dsr_pkg::DSR_RUN;
      dsr_pkg::DSR_TRIP:
        if (fault_reset)
          state_next = dsr_pkg::DSR_IDLE;
      default:
        state_next = dsr_pkg::DSR_TRIP;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= dsr_pkg::DSR_IDLE;
    else
      state_reg <= state_next;
  end

  // Restart interval timer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_reg <= '0;
    else if (state_reg == dsr_pkg::DSR_RUN && state_next == dsr_pkg::DSR_WAIT)
      gap_reg <= GW'(RESTART_GAP_CYC - 1);
    else if (gap_reg != '0)
      gap_reg <= gap_reg - 1'b1;
  end

  // Attempt counter, cleared only by power-on reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      attempt_count <= 3'h0;
    else if (state_reg == dsr_pkg::DSR_WAIT && state_next == dsr_pkg::DSR_RUN)
      attempt_count <= attempt_count + 3'h1;
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motor_run <= 1'h0;
      fault_trip <= 1'h0;
    end
    else
    begin
      motor_run <= state_next == dsr_pkg::DSR_RUN;
      fault_trip <= state_next == dsr_pkg::DSR_TRIP;
    end
  end

  property p_trip_holds;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == dsr_pkg::DSR_TRIP && !fault_reset) |=> state_reg == dsr_pkg::DSR_TRIP;
  endproperty
  a_trip_holds: assert property (p_trip_holds) else $error("trip left without reset");

  property p_count_kept;
    @(posedge ref_clk) disable iff (!rst_n)
      fault_reset |=> attempt_count >= $past(attempt_count);
  endproperty
  a_count_kept: assert property (p_count_kept) else $error("attempt count cleared");

  property p_max_attempts;
    @(posedge ref_clk) disable iff (!rst_n)
      attempt_count <= 3'(MAX_ATTEMPTS);
  endproperty
  a_max_attempts: assert property (p_max_attempts) else $error("too many restarts");

  sequence s_fail_last;
    state_reg == dsr_pkg::DSR_RUN && start_failed && attempt_count == 3'(MAX_ATTEMPTS);
  endsequence
  property p_trip_after_last;
    @(posedge ref_clk) disable iff (!rst_n)
      s_fail_last |=> state_reg == dsr_pkg::DSR_TRIP && fault_trip;
  endproperty
  a_trip_after_last: assert property (p_trip_after_last) else $error("no trip");

  property p_edge_no_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (!auto_start_reg && !armed_reg && state_reg == dsr_pkg::DSR_IDLE) |=> !motor_run;
  endproperty
  a_edge_no_start: assert property (p_edge_no_start) else $error("edge mode started");

  property p_auto_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (auto_start_reg && run_db_reg && state_reg == dsr_pkg::DSR_IDLE) |=> motor_run;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start missed");

  property p_maint_fire;
    @(posedge ref_clk) disable iff (!rst_n)
      (fire_type_reg == `DSR_FIRE_TYPE_MAINT && !fire_active) |=> !fire_mode;
  endproperty
  a_maint_fire: assert property (p_maint_fire) else $error("fire held in maintained");

  property p_unassigned;
    @(posedge ref_clk) disable iff (!rst_n)
      !fire_assigned |=> !fire_mode;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("fire while unassigned");

  property p_latch_holds;
    @(posedge ref_clk) disable iff (!rst_n)
      (fire_mode && fire_type_reg != `DSR_FIRE_TYPE_MAINT && !fire_disable && fire_assigned
       && $stable(fire_type_reg)) |=> fire_mode;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched fire dropped");

endmodule

/* File: dsr_contacts.sv */
/*
  Run switch and fire contact model for the start, restart and fire-mode bench.
  Assumes commands change just after a ref_clk edge; contacts read high when closed.
*/
module dsr_contacts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run_cmd,
  input wire logic fire_cmd,
  output logic run_in,
  output logic fire_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run_p1, run_p2, fire_p1, fire_p2;
  // Each change chatters new, old, new so the debounce has real work to do
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // A contact keeps its commanded level while the drive is held in reset
      {run_p1, run_p2, fire_p1, fire_p2} <= {run_cmd, run_cmd, fire_cmd, fire_cmd};
      run_in <= run_cmd;
      fire_in <= fire_cmd;
    end
    else
    begin
      run_p1 <= run_cmd;
      run_p2 <= run_p1;
      fire_p1 <= fire_cmd;
      fire_p2 <= fire_p1;
      run_in <= run_cmd ^ (run_cmd == run_p1 && run_p1 != run_p2);
      fire_in <= fire_cmd ^ (fire_cmd == fire_p1 && fire_p1 != fire_p2);
    end
  end
endmodule

/* File: drive_start_restart_fire_mode_tb.sv */
/*
  Self-checking bench for the start, restart and fire-mode block.
  Assumes dsr_ctrl and dsr_contacts are compiled first; gap and debounce are shortened.
*/
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module drive_start_restart_fire_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 50;
  logic ref_clk, rst_n, run_cmd, fire_cmd, run_in, fire_in, cfg_valid, cfg_auto_start;
  logic cfg_auto_restart, cfg_fire_pol, cfg_fire_type, fire_assigned, fire_disable;
  logic start_failed, fault_reset, motor_run, fault_trip, fire_mode, pol, typ;
  logic [2:0] attempt_count;
  logic [15:0] lfsr_q = 16'h0713;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n, i, k;

  dsr_contacts i_contacts (.ref_clk(ref_clk), .rst_n(rst_n), .run_cmd(run_cmd),
    .fire_cmd(fire_cmd), .run_in(run_in), .fire_in(fire_in));
  dsr_ctrl #(.RESTART_GAP_CYC(GAP), .MAX_ATTEMPTS(5), .DEBOUNCE_CYC(2)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .run_in(run_in), .fire_in(fire_in),
    .cfg_valid(cfg_valid), .cfg_auto_start(cfg_auto_start),
    .cfg_auto_restart(cfg_auto_restart), .cfg_fire_pol(cfg_fire_pol),
    .cfg_fire_type(cfg_fire_type), .fire_assigned(fire_assigned),
    .fire_disable(fire_disable), .start_failed(start_failed), .fault_reset(fault_reset),
    .motor_run(motor_run), .fault_trip(fault_trip), .fire_mode(fire_mode),
    .attempt_count(attempt_count));

  // Clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #2;
  endtask
  task automatic cfg(input logic a_s, input logic a_r, input logic p, input logic t);
    {cfg_auto_start, cfg_auto_restart, cfg_fire_pol, cfg_fire_type} = {a_s, a_r, p, t};
    cfg_valid = 1'b1;
    step(1);
    cfg_valid = 1'b0;
  endtask
  task automatic wait_run();
    n = 0;
    while (motor_run !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic pulse_fail();
    start_failed = 1'b1;
    step(1);
    start_failed = 1'b0;
    step(2);
  endtask
  task automatic clear_fault();
    fault_reset = 1'b1;
    step(1);
    fault_reset = 1'b0;
    step(2);
  endtask
  task automatic reclose();
    run_cmd = 1'b0;
    step(12);
    run_cmd = 1'b1;
    wait_run();
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence: run switch closed at power on
  initial
  begin
    {rst_n, fire_cmd, cfg_valid, fire_assigned, fire_disable, start_failed} = 6'h00;
    {cfg_auto_start, cfg_auto_restart, cfg_fire_pol, cfg_fire_type, fault_reset} = 5'h00;
    run_cmd = 1'b1;
    step(10);
    rst_n = 1'b1;
    step(20);
    `CHK("edge_hold", 1'b0, motor_run)
    reclose();
    `CHK("edge_start", 1'b1, motor_run)
    pulse_fail();
    `CHK("no_restart_default", 1'b1, fault_trip)
    clear_fault();
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    reclose();
    for (i = 0; i < 6; i++)
    begin
      pulse_fail();
      if (i < 5)
      begin
        `CHK("stopped", 1'b0, motor_run)
        wait_run();
        `CHK("gap", 1'b1, n >= GAP - 4 && n <= GAP + 2)
        `CHK("attempts", 3'(i + 1), attempt_count)
      end
    end
    `CHK("tripped", 1'b1, fault_trip)
    step(GAP + 10);
    `CHK("no_self_start", 1'b0, motor_run)
    clear_fault();
    `CHK("trip_cleared", 1'b0, fault_trip)
    `CHK("count_kept", 3'h5, attempt_count)
    reclose();
    pulse_fail();
    `CHK("exhausted_trip", 1'b1, fault_trip)
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(1);
    `CHK("count_powerup", 3'h0, attempt_count)
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    wait_run();
    `CHK("auto_start", 1'b1, motor_run)
    step(10);
    `CHK("unassigned", 1'b0, fire_mode)
    fire_assigned = 1'b1;
    step(12);
    `CHK("default_nc", 1'b1, fire_mode)
    // Every polarity and type, random pulse widths
    for (k = 0; k < 4; k++)
    begin
      {typ, pol} = 2'(k);
      fire_disable = 1'b1;
      fire_cmd = ~pol;
      cfg(1'b1, 1'b0, pol, typ);
      step(12);
      fire_disable = 1'b0;
      step(4);
      `CHK("fire_idle", 1'b0, fire_mode)
      lfsr_q = lfsr_next(lfsr_q);
      fire_cmd = pol;
      step(12 + 32'(lfsr_q[1:0]));
      `CHK("fire_on", 1'b1, fire_mode)
      fire_cmd = ~pol;
      step(12);
      `CHK("fire_after", typ, fire_mode)
      fire_disable = 1'b1;
      step(4);
      `CHK("fire_off", 1'b0, fire_mode)
    end
    fire_disable = 1'b0;
    fire_cmd = 1'b1;
    fire_assigned = 1'b0;
    step(12);
    `CHK("settings_ignored", 1'b0, fire_mode)
    complete_run();
  end
endmodule
